// file: design/capture_filter.sv
// Purpose: noise canceler and edge detector on the capture path
// Assumes: input already synchronous to i_clk
// Notes:   filter adds FILTER_LEN-1 cycles of delay to the event
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module capture_filter #(
  parameter int FILTER_LEN = `FILTER_LEN_DEFAULT
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_sample,
  input  wire logic i_filter_en,
  input  wire logic i_rising,
  output var  logic o_event
);
  import timer16_pkg::*;

  if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_len
    $error("capture_filter: FILTER_LEN must be 2..16");
  end

  logic [FILTER_LEN-1:0] hist_reg;
  logic [FILTER_LEN-1:0] hist_next;
  logic                  level_reg;
  logic                  level_next;
  logic                  prev_reg;
  logic                  prev_next;
  logic                  event_reg;
  logic                  event_next;
  logic                  level_in;

  // level changes only after FILTER_LEN equal samples in a row
  always_comb begin
    hist_next  = {hist_reg[FILTER_LEN-2:0], i_sample};
    level_next = level_reg;
    if (&hist_next) begin
      level_next = 1'b1;
    end else if (~|hist_next) begin
      level_next = 1'b0;
    end
    // toggling the filter enable may itself look like one edge
    level_in   = i_filter_en ? level_reg : hist_reg[0];
    prev_next  = level_in;
    event_next = i_rising ? (level_in & ~prev_reg)
                          : (~level_in & prev_reg);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hist_reg  <= '0;
      level_reg <= 1'b0;
      prev_reg  <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      hist_reg  <= hist_next;
      level_reg <= level_next;
      prev_reg  <= prev_next;
      event_reg <= event_next;
    end
  end

  assign o_event = event_reg;

endmodule : capture_filter
`default_nettype wire

// file: design/timer16_core.sv
// Purpose: 16-bit timer core with shared high-byte latch and sync control
// Assumes: cpu strobes last one cycle; read data returns on the next cycle
// Notes:   counts upward only; dual-slope modes run as normal mode
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module timer16_core #(
  parameter int FILTER_LEN = `FILTER_LEN_DEFAULT
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire timer16_pkg::io_addr_t i_io_addr,
  input  wire logic                  i_io_wr,
  input  wire logic                  i_io_rd,
  input  wire timer16_pkg::byte_t    i_io_wdata,
  output var  timer16_pkg::byte_t    o_io_rdata,
  input  wire logic                  i_external_count_pin,
  input  wire logic                  i_capture_input_pin,
  input  wire logic                  i_comparator_output,
  input  wire logic                  i_legacy_mode,
  input  wire logic                  i_timer0_async,
  input  wire logic                  i_timer0_reset_done,
  input  wire timer16_pkg::irq_t     i_irq_ack,
  output var  timer16_pkg::irq_t     o_irq_req,
  output wire logic [2:0]            o_compare_output_pin,
  output var  logic                  o_prescaler0_reset,
  output var  logic                  o_shared_prescaler_reset
);
  import timer16_pkg::*;

  if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_len
    $error("timer16_core: FILTER_LEN must be 2..16");
  end

  byte_t                ctrl_a_reg, ctrl_a_next;
  byte_t                ctrl_b_reg, ctrl_b_next;
  byte_t                ctrl_c_reg, ctrl_c_next;
  byte_t                temp_reg, temp_next;
  byte_t                rdata_reg, rdata_next;
  word_t                count_reg, count_next;
  word_t                cap_reg, cap_next;
  irq_t                 flag_reg, flag_next;
  irq_t                 mask_reg, mask_next;
  irq_t                 irq_reg, irq_next;
  logic                 tsm_reg, tsm_next;
  logic                 prescaler0_reset_reg, prescaler0_reset_next;
  logic                 psr_sh_reg, psr_sh_next;
  logic [`PRESC_W-1:0]  presc_reg, presc_next;
  logic                 ext_prev_reg;
  wire  word_t          cmp_buf_w [3];
  wire  word_t          act_w [3];
  wire  logic [2:0]     match_ev;
  wave_mode_t           mode;
  clk_sel_t             csel;
  word_t                top;
  logic                 pwm;
  logic                 at_top;
  logic                 tick;
  logic                 tick_raw;
  logic                 cap_ev;
  logic                 cap_is_top;
  logic                 top_is_a;
  logic                 sfio_wr;
  logic                 cnt_wr;
  logic                 cap_wr;
  logic                 ovf_ev;
  byte_t                cmpa_hi;

  assign sfio_wr = i_io_wr && (i_io_addr == `ADDR_SFIO);
  assign cnt_wr  = i_io_wr && (i_io_addr == `ADDR_CNT_L);
  assign cap_wr  = i_io_wr && (i_io_addr == `ADDR_CAP_L);
  assign mode    = wave_mode_t'({ctrl_b_reg[`CB_WGM_HI +: 2],
                                 ctrl_a_reg[`CA_WGM_LO +: 2]});
  assign csel    = clk_sel_t'(ctrl_b_reg[`CB_CS +: 3]);
  assign cmpa_hi = cmp_buf_w[0][15:8];

  // sync hold and prescaler reset bits
  always_comb begin
    tsm_next    = sfio_wr ? i_io_wdata[`SFIO_TSM] : tsm_reg;
    prescaler0_reset_next   = prescaler0_reset_reg;
    psr_sh_next = psr_sh_reg;
    if (sfio_wr && tsm_reg && !i_io_wdata[`SFIO_TSM]) begin
      prescaler0_reset_next   = 1'b0;
      psr_sh_next = 1'b0;
    end else if (sfio_wr) begin
      prescaler0_reset_next   = i_io_wdata[`SFIO_PRESCALER0_RESET];
      psr_sh_next = i_io_wdata[`SFIO_PSR_SH];
    end else if (tsm_reg) begin
      prescaler0_reset_next   = prescaler0_reset_reg;
      psr_sh_next = psr_sh_reg;
    end else begin
      // async timer 0 needs its own clock edges to finish the reset
      prescaler0_reset_next   = prescaler0_reset_reg && i_timer0_async
                    && !i_timer0_reset_done;
      psr_sh_next = 1'b0;
    end
    presc_next = psr_sh_reg ? '0 : presc_reg + `PRESC_W'(1);
  end

  // tick select and top value
  always_comb begin
    case (csel)
      CS_STOP:     tick_raw = 1'b0;
      CS_DIV1:     tick_raw = 1'b1;
      CS_DIV8:     tick_raw = &presc_reg[2:0];
      CS_DIV64:    tick_raw = &presc_reg[5:0];
      CS_DIV256:   tick_raw = &presc_reg[7:0];
      CS_DIV1024:  tick_raw = &presc_reg[9:0];
      CS_EXT_FALL: tick_raw = ext_prev_reg & ~i_external_count_pin;
      CS_EXT_RISE: tick_raw = ~ext_prev_reg & i_external_count_pin;
      default:     tick_raw = 1'b0;
    endcase
    // a held shared reset freezes every source so timers start together
    tick = tick_raw && !psr_sh_reg;
    case (mode)
      WM_FAST8:    top = `TOP_8BIT;
      WM_FAST9:    top = `TOP_9BIT;
      WM_FAST10:   top = `TOP_10BIT;
      WM_CTC_A,
      WM_FAST_A:   top = act_w[0];
      WM_CTC_CAP,
      WM_FAST_CAP: top = cap_reg;
      default:     top = `VALUE_MAX;
    endcase
    pwm        = (mode == WM_FAST8) || (mode == WM_FAST9)
                 || (mode == WM_FAST10) || (mode == WM_FAST_CAP)
                 || (mode == WM_FAST_A);
    top_is_a   = (mode == WM_CTC_A) || (mode == WM_FAST_A);
    cap_is_top = (mode == WM_CTC_CAP) || (mode == WM_FAST_CAP);
    at_top     = (count_reg == top);
    ovf_ev     = tick && (pwm ? at_top : count_reg == `VALUE_MAX);
  end

  // counter and capture register
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      count_next = at_top ? `VALUE_BOTTOM : count_reg + 16'h0001;
    end
    if (cnt_wr) begin
      count_next = {temp_reg, i_io_wdata};
    end
    cap_next = cap_reg;
    if (cap_ev && !cap_is_top) begin
      cap_next = count_reg;
    end
    if (cap_wr) begin
      cap_next = {temp_reg, i_io_wdata};
    end
  end

  // flags, masks and requests; a set wins over a clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (i_io_wr && i_io_addr == `ADDR_FLAG) begin
      flag_next = flag_next & ~i_io_wdata[4:0];
    end
    flag_next = flag_next & ~i_irq_ack;
    flag_next[`FLAG_OVF] = flag_next[`FLAG_OVF] | ovf_ev;
    flag_next[`FLAG_CMP +: 3] = flag_next[`FLAG_CMP +: 3] | match_ev;
    flag_next[`FLAG_CAP] = flag_next[`FLAG_CAP]
                           | (cap_ev && !cap_is_top);
    if (i_legacy_mode) begin
      flag_next[`FLAG_CMP + 2] = 1'b0;
    end
    mask_next = (i_io_wr && i_io_addr == `ADDR_MASK) ? i_io_wdata[4:0]
                                                     : mask_reg;
    irq_next  = flag_next & mask_next;
  end

  // control registers, shared latch and read data
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    ctrl_c_next = ctrl_c_reg;
    temp_next   = temp_reg;
    rdata_next  = rdata_reg;
    if (i_io_wr) begin
      case (i_io_addr)
        `ADDR_CTRL_A: ctrl_a_next = i_io_wdata;
        `ADDR_CTRL_B: ctrl_b_next = i_io_wdata;
        `ADDR_CTRL_C: ctrl_c_next = i_io_wdata & `CC_WMASK;
        `ADDR_CNT_H, `ADDR_CMPA_H, `ADDR_CMPB_H, `ADDR_CMPC_H,
        `ADDR_CAP_H:  temp_next = i_io_wdata;
        default: ;
      endcase
    end
    if (i_io_rd) begin
      case (i_io_addr)
        `ADDR_CTRL_A: rdata_next = ctrl_a_reg;
        `ADDR_CTRL_B: rdata_next = ctrl_b_reg;
        `ADDR_CTRL_C: rdata_next = ctrl_c_reg;
        `ADDR_CNT_L: begin
          rdata_next = count_reg[7:0];
          temp_next  = count_reg[15:8];
        end
        `ADDR_CAP_L: begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        `ADDR_CNT_H, `ADDR_CAP_H: rdata_next = temp_reg;
        `ADDR_CMPA_L: rdata_next = cmp_buf_w[0][7:0];
        `ADDR_CMPA_H: rdata_next = cmp_buf_w[0][15:8];
        `ADDR_CMPB_L: rdata_next = cmp_buf_w[1][7:0];
        `ADDR_CMPB_H: rdata_next = cmp_buf_w[1][15:8];
        `ADDR_CMPC_L: rdata_next = cmp_buf_w[2][7:0];
        `ADDR_CMPC_H: rdata_next = cmp_buf_w[2][15:8];
        `ADDR_FLAG:   rdata_next = {3'h0, flag_reg};
        `ADDR_MASK:   rdata_next = {3'h0, mask_reg};
        `ADDR_SFIO:   rdata_next = {tsm_reg, 5'h00, prescaler0_reset_reg, psr_sh_reg};
        default:      rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_a_reg   <= `CTRL_RESET;
      ctrl_b_reg   <= `CTRL_RESET;
      ctrl_c_reg   <= `CTRL_RESET;
      temp_reg     <= `TEMP_RESET;
      rdata_reg    <= 8'h00;
      count_reg    <= `VALUE_BOTTOM;
      cap_reg      <= `VALUE_BOTTOM;
      flag_reg     <= '0;
      mask_reg     <= '0;
      irq_reg      <= '0;
      tsm_reg      <= 1'b0;
      prescaler0_reset_reg     <= 1'b0;
      psr_sh_reg   <= 1'b0;
      presc_reg    <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      ctrl_a_reg   <= ctrl_a_next;
      ctrl_b_reg   <= ctrl_b_next;
      ctrl_c_reg   <= ctrl_c_next;
      temp_reg     <= temp_next;
      rdata_reg    <= rdata_next;
      count_reg    <= count_next;
      cap_reg      <= cap_next;
      flag_reg     <= flag_next;
      mask_reg     <= mask_next;
      irq_reg      <= irq_next;
      tsm_reg      <= tsm_next;
      prescaler0_reset_reg     <= prescaler0_reset_next;
      psr_sh_reg   <= psr_sh_next;
      presc_reg    <= presc_next;
      ext_prev_reg <= i_external_count_pin;
    end
  end

  // capture source, noise canceler and edge select
  capture_filter #(
    .FILTER_LEN (FILTER_LEN)
  ) u_capture_filter (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_sample    (ctrl_c_reg[`CC_CAP_SRC] ? i_comparator_output
                                          : i_capture_input_pin),
    .i_filter_en (ctrl_b_reg[`CB_NOISE]),
    .i_rising    (ctrl_b_reg[`CB_EDGE]),
    .o_event     (cap_ev)
  );

  // compare channels: cpu buffer, active compare value and waveform pin
  for (genvar i = 0; i < 3; i++) begin : g_ch
    word_t buf_reg, buf_next;
    word_t act_reg, act_next;
    logic  pin_reg, pin_next;
    logic  en;
    logic  match;
    logic  [1:0] com;

    assign en    = !(i == 2 && i_legacy_mode);
    assign match = (act_reg == count_reg);
    assign com   = ctrl_a_reg[`CA_COM_A - 2*i +: 2];
    assign match_ev[i] = en && tick && match;
    assign cmp_buf_w[i] = en ? buf_reg : `VALUE_BOTTOM;
    assign act_w[i]     = act_reg;
    assign o_compare_output_pin[i] = pin_reg;

    always_comb begin
      buf_next = buf_reg;
      if (en && i_io_wr && i_io_addr == 6'(`ADDR_CMPA_L + 2*i)) begin
        buf_next = {temp_reg, i_io_wdata};
      end
      // pwm modes load the active value from the buffer at top to avoid glitched periods
      act_next = act_reg;
      if (!pwm) begin
        act_next = buf_next;
      end else if (tick && at_top) begin
        act_next = buf_reg;
      end
      pin_next = pin_reg;
      if (!en) begin
        pin_next = 1'b0;
      end else if (tick) begin
        if (!pwm) begin
          if (match) begin
            case (com)
              2'b01:   pin_next = ~pin_reg;
              2'b10:   pin_next = 1'b0;
              2'b11:   pin_next = 1'b1;
              default: pin_next = pin_reg;
            endcase
          end
        end else if (i == 0 && top_is_a) begin
          if (match && com == 2'b01) begin
            pin_next = ~pin_reg;
          end
        end else if (com[1]) begin
          if (match) begin
            pin_next = com[0];
          end else if (at_top) begin
            pin_next = ~com[0];
          end
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        buf_reg <= `VALUE_BOTTOM;
        act_reg <= `VALUE_BOTTOM;
        pin_reg <= 1'b0;
      end else begin
        buf_reg <= buf_next;
        act_reg <= act_next;
        pin_reg <= pin_next;
      end
    end
  end

  assign o_io_rdata               = rdata_reg;
  assign o_irq_req                = irq_reg;
  assign o_prescaler0_reset       = prescaler0_reset_reg;
  assign o_shared_prescaler_reset = psr_sh_reg;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_release;
    tsm_reg && sfio_wr && !i_io_wdata[`SFIO_TSM];
  endsequence
  sequence s_cnt_low_read;
    i_io_rd && i_io_addr == `ADDR_CNT_L;
  endsequence

  property p_hold_in_sync;
    tsm_reg && !sfio_wr |=> $stable(prescaler0_reset_reg) && $stable(psr_sh_reg);
  endproperty
  a_hold_in_sync: assert property (p_hold_in_sync)
    else $error("prescaler reset bits changed under sync hold");
  property p_release_clears;
    s_release |=> !prescaler0_reset_reg && !psr_sh_reg && !tsm_reg;
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("releasing sync hold left a prescaler reset set");
  property p_prescaler0_reset_self_clear;
    prescaler0_reset_reg && !tsm_reg && !sfio_wr && !i_timer0_async |=> !prescaler0_reset_reg;
  endproperty
  a_prescaler0_reset_self_clear: assert property (p_prescaler0_reset_self_clear)
    else $error("prescaler0 reset did not clear itself");
  property p_prescaler0_reset_async_hold;
    prescaler0_reset_reg && !tsm_reg && !sfio_wr && i_timer0_async
      && !i_timer0_reset_done |=> prescaler0_reset_reg;
  endproperty
  a_prescaler0_reset_async_hold: assert property (p_prescaler0_reset_async_hold)
    else $error("prescaler0 reset cleared before async completion");
  property p_stopped;
    (csel == CS_STOP || psr_sh_reg) && !cnt_wr |=> $stable(count_reg);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved with no tick source");
  property p_low_write;
    cnt_wr |=> count_reg == {$past(temp_reg), $past(i_io_wdata)};
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("counter low write did not load latch and data");
  property p_low_read;
    s_cnt_low_read |=> temp_reg == 8'($past(count_reg) >> 8)
      ##1 (i_io_rd && i_io_addr == `ADDR_CNT_H && !i_io_wr)
      |=> o_io_rdata == $past(temp_reg);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("latch or high read wrong after low read");
  property p_cmp_bypass;
    i_io_rd && i_io_addr == `ADDR_CMPA_H |=> o_io_rdata == $past(cmpa_hi);
  endproperty
  a_cmp_bypass: assert property (p_cmp_bypass)
    else $error("compare high read went through the latch");
  property p_capture;
    cap_ev && !cap_is_top && !cap_wr
      |=> cap_reg == $past(count_reg) && flag_reg[`FLAG_CAP];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag missing");
  property p_ovf_set_wins;
    ovf_ev |=> flag_reg[`FLAG_OVF]
      && (o_irq_req[`FLAG_OVF] == mask_reg[`FLAG_OVF]);
  endproperty
  a_ovf_set_wins: assert property (p_ovf_set_wins)
    else $error("overflow flag lost or request not raised");

endmodule : timer16_core
`default_nettype wire

// file: design/timer16_defs.svh
// Operation
// - with sync hold set, written prescaler-reset bits stay, halting counters
// - clearing sync hold clears both prescaler-reset bits so counters start
// - writing prescaler0 reset resets it; the bit clears itself next cycle
// - with timer 0 asynchronous, the bit stays one until reset completes
// - sync hold sits in bit 7 of the special function control
// - tick comes from prescaler or external pin edge; stopped when none
// - three double-buffered compare channels; a match sets its flag; the code buffers only in pwm modes
// - each compare match drives a waveform onto its compare output pin
// - capture copies counter on selected edge; pin or comparator; filter
// - top is 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode
// - compare A as pwm top gives no pwm on A; top buffered
// - bottom is 0x0000 and maximum is 0xFFFF
// - one shared 8-bit high-byte latch serves all 16-bit registers
// - low byte write loads latch and data into register at once
// - low byte read copies high byte into the latch; high read returns it
// - compare register high-byte reads bypass the latch
// - 8-bit control registers read and write directly
// - every timer flag is visible and has its own mask bit
// - legacy mode keeps only compare channels A and B
// - a counter write beats any count or clear in that cycle
// - capture flag sets with capture; cleared by service or written one
//
// Purpose: offsets, field positions, reset values and counts of the timer
// Assumes: 6-bit i/o addresses, one register per address
// Notes:   included by bare name; definitions only
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// i/o register addresses
`define ADDR_CTRL_A   6'h00
`define ADDR_CTRL_B   6'h01
`define ADDR_CTRL_C   6'h02
`define ADDR_CNT_L    6'h03
`define ADDR_CNT_H    6'h04
`define ADDR_CMPA_L   6'h05
`define ADDR_CMPA_H   6'h06
`define ADDR_CMPB_L   6'h07
`define ADDR_CMPB_H   6'h08
`define ADDR_CMPC_L   6'h09
`define ADDR_CMPC_H   6'h0A
`define ADDR_CAP_L    6'h0B
`define ADDR_CAP_H    6'h0C
`define ADDR_FLAG     6'h0D
`define ADDR_MASK     6'h0E
`define ADDR_SFIO     6'h0F

// field positions
`define CA_COM_A      6
`define CA_WGM_LO     0
`define CB_NOISE      7
`define CB_EDGE       6
`define CB_WGM_HI     3
`define CB_CS         0
`define CC_CAP_SRC    0
`define SFIO_TSM      7
`define SFIO_PRESCALER0_RESET     1
`define SFIO_PSR_SH   0
`define FLAG_OVF      0
`define FLAG_CMP      1
`define FLAG_CAP      4

// reset values and write masks
`define CTRL_RESET    8'h00
`define TEMP_RESET    8'h00
`define CC_WMASK      8'h01

// counter values
`define TOP_8BIT      16'h00FF
`define TOP_9BIT      16'h01FF
`define TOP_10BIT     16'h03FF
`define VALUE_MAX     16'hFFFF
`define VALUE_BOTTOM  16'h0000

// counts
`define PRESC_W       10
`define FILTER_LEN_DEFAULT 4

`endif

// file: design/timer16_pkg.sv
// Purpose: shared types of the 16-bit timer
// Assumes: constants live in timer16_defs.svh
// Notes:   mode codes outside the enum behave as normal mode
package timer16_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [5:0]  io_addr_t;
  typedef logic [4:0]  irq_t;

  typedef enum logic [3:0] {
    WM_NORMAL   = 4'h0,
    WM_CTC_A    = 4'h4,
    WM_FAST8    = 4'h5,
    WM_FAST9    = 4'h6,
    WM_FAST10   = 4'h7,
    WM_CTC_CAP  = 4'hC,
    WM_FAST_CAP = 4'hE,
    WM_FAST_A   = 4'hF
  } wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP     = 3'h0,
    CS_DIV1     = 3'h1,
    CS_DIV8     = 3'h2,
    CS_DIV64    = 3'h3,
    CS_DIV256   = 3'h4,
    CS_DIV1024  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clk_sel_t;

endpackage : timer16_pkg

// file: test/cpu_bus_model.sv
// Purpose: processor core side of the 8-bit i/o bus
// Assumes: one strobe per access, one cycle long
// Notes:   idle lines are inverted so stale values never help
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input  wire logic                  i_clk,
  output var  timer16_pkg::io_addr_t o_io_addr,
  output var  logic                  o_io_wr,
  output var  logic                  o_io_rd,
  output var  timer16_pkg::byte_t    o_io_wdata
);
  import timer16_pkg::*;
  // quiet bus at time zero
  initial begin
    o_io_addr  = 6'h3F;
    o_io_wr    = 1'b0;
    o_io_rd    = 1'b0;
    o_io_wdata = 8'h00;
  end
  // strobe held up to the sampling edge, released right after it
  task automatic access(input io_addr_t a, input byte_t d, input logic w);
    @(posedge i_clk);
    o_io_addr  <= a;
    o_io_wdata <= d;
    o_io_wr    <= w;
    o_io_rd    <= ~w;
    @(posedge i_clk);
    o_io_wr    <= 1'b0;
    o_io_rd    <= 1'b0;
    o_io_addr  <= ~a;
    o_io_wdata <= ~d;
  endtask : access
  // high byte first so the latch is loaded before the low byte lands
  task automatic wr16(input io_addr_t lo, input word_t v);
    access(lo + 6'h01, v[15:8], 1'b1);
    access(lo, v[7:0], 1'b1);
  endtask : wr16
endmodule : cpu_bus_model
`default_nettype wire

// file: test/test_sixteen_bit_timer_access_sync.sv
// Purpose: self-checking bench for the 16-bit timer core
// Assumes: read data answers one cycle after the strobe edge
// Notes:   expected bytes queue up; a monitor pops them in order
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module test_sixteen_bit_timer_access_sync;
  import timer16_pkg::*;
  localparam int FLEN = 3;
  logic       i_clk, i_resetn, ext_pin, cap_pin, cmp_out, legacy;
  logic       t0_async, t0_done, wr, rd, t0_presc_rst, sh_presc_rst, pend;
  logic [2:0] pins;
  io_addr_t   addr;
  byte_t      wdata, rdata, exp_q[$];
  irq_t       ack, irq;
  word_t      w;
  int         fail_count, check_count;
  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  cpu_bus_model cpu (.i_clk(i_clk), .o_io_addr(addr), .o_io_wr(wr),
    .o_io_rd(rd), .o_io_wdata(wdata));
  timer16_core #(.FILTER_LEN(FLEN)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .i_external_count_pin(ext_pin), .i_capture_input_pin(cap_pin),
    .i_comparator_output(cmp_out), .i_legacy_mode(legacy),
    .i_timer0_async(t0_async), .i_timer0_reset_done(t0_done),
    .i_irq_ack(ack), .o_irq_req(irq), .o_compare_output_pin(pins),
    .o_prescaler0_reset(t0_presc_rst),
    .o_shared_prescaler_reset(sh_presc_rst));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // rising then falling edge on the external count pin, n times
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge i_clk) ext_pin <= 1'b1;
      cyc(2);
      @(posedge i_clk) ext_pin <= 1'b0;
      cyc(2);
    end
  endtask : pulse_ext
  task automatic check(input string what, input byte_t seen, input byte_t e);
    check_count++;
    if (seen !== e) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", what, e, seen);
    end
  endtask : check
  task automatic rd8(input io_addr_t a, input byte_t e);
    exp_q.push_back(e);
    cpu.access(a, 8'h00, 1'b0);
  endtask : rd8
  // low byte first: it fills the latch the high read returns
  task automatic rd16(input io_addr_t lo, input word_t e);
    rd8(lo, e[7:0]);
    rd8(lo + 6'h01, e[15:8]);
  endtask : rd16
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // each answer is compared with the oldest noted byte
  always @(posedge i_clk) begin
    if (pend) begin
      check("read data", rdata, exp_q.pop_front());
    end
    pend <= rd;
  end
  // whole sequence needs well under 1000 cycles
  initial begin
    cyc(5000);
    fail_count++;
    results();
  end
  initial begin
    {i_resetn, ext_pin, cap_pin, cmp_out, legacy, t0_async, t0_done} = '0;
    ack = '0;
    void'($urandom(32'h2640_4552));
    cyc(20);
    i_resetn <= 1'b1;
    rd8(`ADDR_SFIO, 8'h00);
    rd8(`ADDR_CNT_H, 8'h00);
    rd8(6'h3F, 8'h00);
    w = word_t'($urandom);
    cpu.access(`ADDR_CTRL_A, w[7:0], 1'b1);
    rd8(`ADDR_CTRL_A, w[7:0]);
    cpu.access(`ADDR_CTRL_A, 8'h00, 1'b1);
    cpu.wr16(`ADDR_CNT_L, w);
    rd16(`ADDR_CNT_L, w);
    // lone low write takes whatever high byte another register left
    cpu.wr16(`ADDR_CMPB_L, w);
    cpu.access(`ADDR_CMPA_H, ~w[15:8], 1'b1);
    cpu.access(`ADDR_CNT_L, 8'h5A, 1'b1);
    rd8(`ADDR_CNT_L, 8'h5A);
    rd8(`ADDR_CMPA_H, 8'h00);
    rd8(`ADDR_CMPB_H, w[15:8]);
    rd8(`ADDR_CNT_H, ~w[15:8]);
    @(posedge i_clk) legacy <= 1'b1;
    cpu.wr16(`ADDR_CMPC_L, w);
    rd8(`ADDR_CMPC_L, 8'h00);
    @(posedge i_clk) legacy <= 1'b0;
    $display("test word access done");
    cpu.wr16(`ADDR_CNT_L, 16'h0000);
    cpu.access(`ADDR_SFIO, 8'h83, 1'b1);
    cpu.access(`ADDR_CTRL_B, 8'h01, 1'b1);
    cyc(4);
    check("resets", {6'h00, t0_presc_rst, sh_presc_rst}, 8'h03);
    rd8(`ADDR_SFIO, 8'h83);
    rd16(`ADDR_CNT_L, 16'h0000);
    cpu.access(`ADDR_SFIO, 8'h03, 1'b1);
    rd8(`ADDR_SFIO, 8'h00);
    cpu.access(`ADDR_SFIO, 8'h02, 1'b1);
    #1 check("prescaler0 pulse", {7'h00, t0_presc_rst}, 8'h01);
    rd8(`ADDR_SFIO, 8'h00);
    cpu.access(`ADDR_CTRL_B, 8'h00, 1'b1);
    @(posedge i_clk) t0_async <= 1'b1;
    cpu.access(`ADDR_SFIO, 8'h02, 1'b1);
    cyc(3);
    rd8(`ADDR_SFIO, 8'h02);
    @(posedge i_clk) t0_done <= 1'b1;
    @(posedge i_clk) t0_done <= 1'b0;
    rd8(`ADDR_SFIO, 8'h00);
    @(posedge i_clk) t0_async <= 1'b0;
    $display("test sync control done");
    cpu.wr16(`ADDR_CNT_L, 16'h0000);
    cpu.access(`ADDR_CTRL_B, {5'h00, CS_EXT_RISE}, 1'b1);
    pulse_ext(3);
    cyc(3);
    rd16(`ADDR_CNT_L, 16'h0003);
    // matches at 1..3 and the wrap all land within a few ticks
    for (int i = 0; i < 3; i++) begin
      cpu.wr16(io_addr_t'(`ADDR_CMPA_L + 2 * i), word_t'(i + 1));
    end
    cpu.access(`ADDR_CTRL_B, 8'h00, 1'b1);
    cpu.access(`ADDR_FLAG, 8'hFF, 1'b1);
    cpu.access(`ADDR_MASK, 8'h0F, 1'b1);
    // pin A toggles, pin B clears, pin C sets on their matches
    cpu.access(`ADDR_CTRL_A, 8'h6C, 1'b1);
    cpu.wr16(`ADDR_CNT_L, 16'hFFFE);
    cpu.access(`ADDR_CTRL_B, 8'h01, 1'b1);
    cyc(8);
    cpu.access(`ADDR_CTRL_B, 8'h00, 1'b1);
    check("requests", {3'h0, irq}, 8'h0F);
    check("compare pins", {5'h00, pins}, 8'h05);
    rd8(`ADDR_FLAG, 8'h0F);
    cpu.access(`ADDR_FLAG, 8'h0F, 1'b1);
    rd8(`ADDR_FLAG, 8'h00);
    // clear on compare A with top 1: three ticks end at 1, not 3
    cpu.wr16(`ADDR_CNT_L, 16'h0000);
    cpu.access(`ADDR_CTRL_B, 8'h0F, 1'b1);
    pulse_ext(3);
    rd16(`ADDR_CNT_L, 16'h0001);
    cpu.access(`ADDR_CTRL_B, 8'h00, 1'b1);
    $display("test ticks and flags done");
    cpu.access(`ADDR_MASK, 8'h10, 1'b1);
    for (int s = 0; s < 2; s++) begin
      w = word_t'($urandom);
      cpu.wr16(`ADDR_CNT_L, w);
      cpu.access(`ADDR_CTRL_C, byte_t'(s), 1'b1);
      cpu.access(`ADDR_CTRL_B, {s[0], 7'h40}, 1'b1);
      @(posedge i_clk) {cmp_out, cap_pin} <= s[0] ? 2'b10 : 2'b01;
      cyc(FLEN + 6);
      check("capture request", {3'h0, irq}, 8'h10);
      rd16(`ADDR_CAP_L, w);
      @(posedge i_clk) {ack, cmp_out, cap_pin} <= {5'h10, 2'b00};
      @(posedge i_clk) ack <= 5'h00;
      cyc(2);
      check("serviced request", {3'h0, irq}, 8'h00);
    end
    $display("test capture done");
    cyc(3);
    results();
  end
endmodule : test_sixteen_bit_timer_access_sync
`default_nettype wire
